// File: tcc_cfg.svh
// Offsets, field positions, reset values and identity codes of the bank
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TCC_ADDR_CH0_TRACK 8'h25
`define TCC_ADDR_CH3_SETUP 8'h26
`define TCC_ADDR_CH12_TRACK 8'h28
`define TCC_ADDR_CH3_TRACK 8'h2b
`define TCC_ADDR_MAKER_LO 8'hfc
`define TCC_ADDR_MAKER_HI 8'hfd
`define TCC_ADDR_PART_LO 8'hfe
`define TCC_ADDR_PART_HI 8'hff

// ----------------------------------------------------------------
// Field positions (least significant bit)
// ----------------------------------------------------------------
`define TCC_CH0_FT_LSB 1
`define TCC_CH1_FT_LSB 4
`define TCC_CH2_FT_LSB 6
`define TCC_CH3_FT_LSB 0
`define TCC_RRANGE_BIT 7
`define TCC_FREQ_LSB 5
`define TCC_CYC_LSB 0

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define TCC_FT_RST 2'h1
`define TCC_RRANGE_RST 1'h0
`define TCC_FREQ_RST 2'h0
`define TCC_FREQ_RSVD 2'h3
`define TCC_CYC_RST 5'h04

// ----------------------------------------------------------------
// Identity codes (arbitrary values)
// ----------------------------------------------------------------
`define TCC_MAKER_CODE 16'h5a3c
`define TCC_PART_HI 8'h7e
`define TCC_PART_LO_4CH 8'h0a
`define TCC_PART_LO_2CH 8'h0b

`endif

// File: tcc_pkg.sv
// Types shared by the channel configuration bank
package tcc_pkg;

    typedef logic [1:0] tcc_track_t;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tcc_req_s;

    typedef struct packed {
        tcc_track_t [3:0] fast_track;
        logic chan3_resistance_range;
        logic [1:0] chan3_frequency_range;
        logic [4:0] chan3_cycle_count;
    } tcc_cfg_s;

endpackage

// File: tcc_id_rom.sv
// Fixed identification bytes for maker and part codes
`timescale 1ns/100ps
`include "tcc_cfg.svh"

module tcc_id_rom #(
    parameter bit FOUR_CHAN = 1'b1
) (
    input wire logic [1:0] sel,
    output logic [7:0] id_byte
);
    logic [15:0] maker_code;
    logic [15:0] part_code;

    assign maker_code = `TCC_MAKER_CODE;
    // Low part byte tells the two variants apart
    assign part_code = {`TCC_PART_HI,
                        FOUR_CHAN ? `TCC_PART_LO_4CH : `TCC_PART_LO_2CH};

    always_comb begin
        case (sel)
            2'h0: id_byte = maker_code[7:0];
            2'h1: id_byte = maker_code[15:8];
            2'h2: id_byte = part_code[7:0];
            default: id_byte = part_code[15:8];
        endcase
    end
endmodule

// File: tcc_count_scale.sv
// Per-channel frequency counter scaling
`timescale 1ns/100ps

module tcc_count_scale (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [3:0][1:0] counter_scale,
    input wire logic [3:0][15:0] raw_counts,
    output logic [3:0][15:0] scaled_counts
);
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1) begin : g_chan
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    scaled_counts[ch] <= 16'h0000;
                end else begin
                    scaled_counts[ch] <=
                        raw_counts[ch] >> counter_scale[ch];
                end
            end
        end
    endgenerate
endmodule

// File: tcc_regs.sv
// Channel tracking and channel 3 sensor configuration register bank
// ----------------------------------------------------------------
// What this block does
// - Channel 0 fast tracking, bits 2:1, reset 1
// - Channel 1 fast tracking, bits 5:4, reset 1
// - Channel 2 fast tracking, bits 7:6, four-channel only
// - Channel 3 fast tracking, bits 1:0, four-channel only
// - Channel 3 bit 7 selects resistance range
// - Channel 3 bits 6:5 select frequency range
// - Channel 3 bits 4:0 hold cycle count
// - Read-only maker code at 0xFC/0xFD
// - Read-only part code at 0xFE/0xFF, variant-specific
// - Counter scale shifts channel frequency count
// ----------------------------------------------------------------
`timescale 1ns/100ps
`include "tcc_cfg.svh"

module tcc_regs
    import tcc_pkg::*;
#(
    parameter bit FOUR_CHAN = 1'b1
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire tcc_req_s reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic conv_start,
    input wire logic [3:0][1:0] counter_scale,
    input wire logic [3:0][15:0] raw_counts,
    output logic [3:0][15:0] scaled_counts,
    output tcc_cfg_s cfg_out
);

    // ------------------------------------------------------------
    // Storage and decode
    // ------------------------------------------------------------
    tcc_track_t [3:0] ft_r;
    logic rrange_r;
    logic [1:0] freq_r;
    logic [4:0] cyc_r;
    logic [7:0] rdata_nxt;
    logic [7:0] id_byte;
    logic hit_ch0;
    logic hit_ch12;
    logic hit_ch3t;
    logic hit_ch3s;
    logic hit_id;
    tcc_cfg_s live_cfg;

    assign hit_ch0 = reg_req.addr == `TCC_ADDR_CH0_TRACK;
    assign hit_ch12 = reg_req.addr == `TCC_ADDR_CH12_TRACK;
    assign hit_ch3t = reg_req.addr == `TCC_ADDR_CH3_TRACK;
    assign hit_ch3s = reg_req.addr == `TCC_ADDR_CH3_SETUP;
    assign hit_id = reg_req.addr[7:2] == 6'(`TCC_ADDR_MAKER_LO >> 2);

    // ------------------------------------------------------------
    // Fast tracking factors
    // ------------------------------------------------------------
    // Reserved bits are not stored, so they always read back zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ft_r <= {4{`TCC_FT_RST}};
        end else if (reg_req.wr_en) begin
            if (hit_ch0) begin
                ft_r[0] <= reg_req.wdata[`TCC_CH0_FT_LSB +: 2];
            end
            if (hit_ch12) begin
                ft_r[1] <= reg_req.wdata[`TCC_CH1_FT_LSB +: 2];
                if (FOUR_CHAN) begin
                    ft_r[2] <= reg_req.wdata[`TCC_CH2_FT_LSB +: 2];
                end
            end
            if (hit_ch3t && FOUR_CHAN) begin
                ft_r[3] <= reg_req.wdata[`TCC_CH3_FT_LSB +: 2];
            end
        end
    end

    // ------------------------------------------------------------
    // Channel 3 sensor setup
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rrange_r <= `TCC_RRANGE_RST;
            freq_r <= `TCC_FREQ_RST;
            cyc_r <= `TCC_CYC_RST;
        end else if (reg_req.wr_en && hit_ch3s && FOUR_CHAN) begin
            rrange_r <= reg_req.wdata[`TCC_RRANGE_BIT];
            // Reserved frequency code keeps the previous range
            if (reg_req.wdata[`TCC_FREQ_LSB +: 2] != `TCC_FREQ_RSVD) begin
                freq_r <= reg_req.wdata[`TCC_FREQ_LSB +: 2];
            end
            cyc_r <= reg_req.wdata[`TCC_CYC_LSB +: 5];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    tcc_id_rom #(
        .FOUR_CHAN(FOUR_CHAN)
    ) u_id_rom (
        .sel(reg_req.addr[1:0]),
        .id_byte(id_byte)
    );

    always_comb begin
        rdata_nxt = 8'h00;
        if (hit_id) begin
            rdata_nxt = id_byte;
        end else if (hit_ch0) begin
            rdata_nxt[`TCC_CH0_FT_LSB +: 2] = ft_r[0];
        end else if (hit_ch12) begin
            rdata_nxt[`TCC_CH1_FT_LSB +: 2] = ft_r[1];
            rdata_nxt[`TCC_CH2_FT_LSB +: 2] = ft_r[2];
        end else if (hit_ch3t) begin
            rdata_nxt[`TCC_CH3_FT_LSB +: 2] = ft_r[3];
        end else if (hit_ch3s) begin
            rdata_nxt[`TCC_RRANGE_BIT] = rrange_r;
            rdata_nxt[`TCC_FREQ_LSB +: 2] = freq_r;
            rdata_nxt[`TCC_CYC_LSB +: 5] = cyc_r;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd_en;
            if (reg_req.rd_en) begin
                reg_rdata <= rdata_nxt;
            end
        end
    end

    // ------------------------------------------------------------
    // Settings handed to measurement at conversion start
    // ------------------------------------------------------------
    assign live_cfg.fast_track = ft_r;
    assign live_cfg.chan3_resistance_range = rrange_r;
    assign live_cfg.chan3_frequency_range = freq_r;
    assign live_cfg.chan3_cycle_count = cyc_r;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_out <= {{4{`TCC_FT_RST}}, `TCC_RRANGE_RST, `TCC_FREQ_RST,
                        `TCC_CYC_RST};
        end else if (conv_start) begin
            cfg_out <= live_cfg;
        end
    end

    tcc_count_scale u_count_scale (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .counter_scale(counter_scale),
        .raw_counts(raw_counts),
        .scaled_counts(scaled_counts)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [7:0] wdata_q;
    logic [15:0] raw0_q;
    logic [1:0] scale0_q;
    logic [15:0] raw3_q;
    logic [1:0] scale3_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wdata_q <= 8'h00;
            raw0_q <= 16'h0000;
            scale0_q <= 2'h0;
            raw3_q <= 16'h0000;
            scale3_q <= 2'h0;
        end else begin
            wdata_q <= reg_req.wdata;
            raw0_q <= raw_counts[0];
            scale0_q <= counter_scale[0];
            raw3_q <= raw_counts[3];
            scale3_q <= counter_scale[3];
        end
    end

    ch0_track_write_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reg_req.wr_en && hit_ch0 |=> ft_r[0] == wdata_q[2:1])
        else $error("channel 0 tracking factor not stored");

    ch1_track_write_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reg_req.wr_en && hit_ch12 |=> ft_r[1] == wdata_q[5:4])
        else $error("channel 1 tracking factor not stored");

    ch2_track_write_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reg_req.wr_en && hit_ch12 |=>
            ft_r[2] == (FOUR_CHAN ? wdata_q[7:6] : $past(ft_r[2])))
        else $error("channel 2 tracking factor wrong");

    ch3_track_write_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reg_req.wr_en && hit_ch3t |=>
            ft_r[3] == (FOUR_CHAN ? wdata_q[1:0] : $past(ft_r[3])))
        else $error("channel 3 tracking factor wrong");

    rsvd_read_zero_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reg_req.rd_en && hit_ch0 |=>
            reg_rvalid && reg_rdata[7:3] == 5'h00 && !reg_rdata[0])
        else $error("reserved tracking bits read nonzero");

    range_write_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reg_req.wr_en && hit_ch3s && FOUR_CHAN |=> rrange_r == wdata_q[7])
        else $error("resistance range not stored");

    freq_rsvd_hold_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reg_req.wr_en && hit_ch3s && reg_req.wdata[6:5] == 2'h3 |=>
            $stable(freq_r) && freq_r != 2'h3)
        else $error("reserved frequency code accepted");

    cycle_write_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reg_req.wr_en && hit_ch3s && FOUR_CHAN |=> cyc_r == wdata_q[4:0])
        else $error("cycle count not stored");

    maker_read_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reg_req.rd_en && reg_req.addr == 8'hfd |=>
            reg_rdata == 8'h5a && reg_rvalid)
        else $error("maker code high byte wrong");

    part_read_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reg_req.rd_en && reg_req.addr == 8'hfe |=>
            reg_rdata == (FOUR_CHAN ? 8'h0a : 8'h0b))
        else $error("part code low byte wrong");

    scale_shift_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        $past(reset_n) |-> scaled_counts[0] == (raw0_q >> scale0_q))
        else $error("channel 0 count not scaled");

    apply_cfg_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        conv_start ##1 !conv_start [*2] |->
            cfg_out == $past(live_cfg, 2) && $stable(cfg_out))
        else $error("settings not applied at conversion start");

    ch0_read_back_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reg_req.rd_en && hit_ch0 |=> reg_rdata[2:1] == $past(ft_r[0]))
        else $error("channel 0 tracking factor read wrong");

    ch12_read_back_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reg_req.rd_en && hit_ch12 |=>
            reg_rdata == {$past(ft_r[2]), $past(ft_r[1]), 4'h0})
        else $error("channel 1 and 2 tracking factors read wrong");

    ch3_read_back_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reg_req.rd_en && hit_ch3t |=>
            reg_rdata == {6'h00, $past(ft_r[3])})
        else $error("channel 3 tracking factor read wrong");

    setup_read_back_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reg_req.rd_en && hit_ch3s |=>
            reg_rdata == {$past(rrange_r), $past(freq_r), $past(cyc_r)})
        else $error("channel 3 sensor setup read wrong");

    id_write_ignored_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reg_req.wr_en && hit_id |=> $stable(ft_r) && $stable(rrange_r) &&
            $stable(freq_r) && $stable(cyc_r))
        else $error("identity write changed a setting");

    cfg_hold_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !conv_start |=> $stable(cfg_out))
        else $error("settings changed without conversion start");

    maker_low_read_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reg_req.rd_en && reg_req.addr == `TCC_ADDR_MAKER_LO |=>
            reg_rdata == 8'(`TCC_MAKER_CODE) && reg_rvalid)
        else $error("maker code low byte wrong");

    part_high_read_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reg_req.rd_en && reg_req.addr == `TCC_ADDR_PART_HI |=>
            reg_rdata == `TCC_PART_HI && reg_rvalid)
        else $error("part code high byte wrong");

    freq_legal_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        freq_r != `TCC_FREQ_RSVD)
        else $error("reserved frequency range stored");

    scale_ch3_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        $past(reset_n) |-> scaled_counts[3] == (raw3_q >> scale3_q))
        else $error("channel 3 count not scaled");

endmodule

// File: tcc_host.sv
// Host model driving the register port of the configuration bank
`timescale 1ns/100ps
`include "tcc_cfg.svh"

module tcc_host
    import tcc_pkg::*;
(
    input wire logic sys_clk,
    output tcc_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_req = '0;
    end

    // Bits the host may set; reserved tracking bits go out as zero
    function automatic logic [7:0] keep_mask(input logic [7:0] a);
        case (a)
            `TCC_ADDR_CH0_TRACK: keep_mask = 8'h06;
            `TCC_ADDR_CH12_TRACK: keep_mask = 8'hf0;
            `TCC_ADDR_CH3_TRACK: keep_mask = 8'h03;
            default: keep_mask = 8'hff;
        endcase
    endfunction

    // Released fields show stale-looking garbage, not the last value
    task automatic idle();
        reg_req.wr_en = 1'b0;
        reg_req.rd_en = 1'b0;
        reg_req.addr = ~reg_req.addr;
        reg_req.wdata = ~reg_req.wdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_req.wr_en = 1'b1;
        reg_req.addr = a;
        reg_req.wdata = d & keep_mask(a);
        @(posedge sys_clk);
        #1;
        idle();
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic vld);
        @(posedge sys_clk);
        #1;
        reg_req.rd_en = 1'b1;
        reg_req.addr = a;
        @(posedge sys_clk);
        #1;
        idle();
        d = reg_rdata;
        vld = reg_rvalid;
    endtask
endmodule

// File: tb_top.sv
// Self-checking testbench of the channel configuration bank
`timescale 1ns/100ps
`include "tcc_cfg.svh"

module tb_top
    import tcc_pkg::*;
;
    logic sys_clk;
    logic reset_n;
    tcc_req_s reg_req;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic conv_start;
    logic [3:0][1:0] counter_scale;
    logic [3:0][15:0] raw_counts;
    logic [3:0][15:0] scaled_counts;
    tcc_cfg_s cfg_out;
    logic [7:0] rdata_2ch;
    logic rvalid_2ch;
    logic [3:0][15:0] scaled_2ch;
    tcc_cfg_s cfg_2ch;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    localparam logic [15:0] MAKER = `TCC_MAKER_CODE;
    logic [7:0] id_adr [4] = '{8'hfc, 8'hfd, 8'hfe, 8'hff};
    logic [7:0] id_val [4] = '{MAKER[7:0], MAKER[15:8],
                               `TCC_PART_LO_4CH, `TCC_PART_HI};

    tcc_regs #(.FOUR_CHAN(1'b1)) u_tcc_regs (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .conv_start(conv_start),
        .counter_scale(counter_scale),
        .raw_counts(raw_counts),
        .scaled_counts(scaled_counts),
        .cfg_out(cfg_out)
    );

    // Two-channel variant sees the same requests
    tcc_regs #(.FOUR_CHAN(1'b0)) u_tcc_regs_2ch (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .reg_req(reg_req),
        .reg_rdata(rdata_2ch),
        .reg_rvalid(rvalid_2ch),
        .conv_start(conv_start),
        .counter_scale(counter_scale),
        .raw_counts(raw_counts),
        .scaled_counts(scaled_2ch),
        .cfg_out(cfg_2ch)
    );

    tcc_host u_tcc_host (
        .sys_clk(sys_clk),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic vld;
        u_tcc_host.rd(a, d, vld);
        check("read valid", {15'h0000, vld}, 16'h0001);
        check("read data", {8'h00, d}, {8'h00, exp});
    endtask

    task automatic rd_two(input logic [7:0] a, input logic [7:0] exp4,
                          input logic [7:0] exp2);
        rd_chk(a, exp4);
        check("2ch read valid", {15'h0000, rvalid_2ch}, 16'h0001);
        check("2ch read data", {8'h00, rdata_2ch}, {8'h00, exp2});
    endtask

    task automatic pulse_conv();
        @(posedge sys_clk);
        #1;
        conv_start = 1'b1;
        @(posedge sys_clk);
        #1;
        conv_start = 1'b0;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        check("cfg reset", cfg_out, 16'h5504);
        rd_chk(8'h25, 8'h02);
        rd_chk(8'h26, 8'h04);
        rd_chk(8'h28, 8'h50);
        rd_chk(8'h2b, 8'h01);
    endtask

    task automatic test_track();
        logic [1:0] f0;
        for (int v = 0; v < 4; v++) begin
            f0 = v[1:0];
            u_tcc_host.wr(8'h25, {5'h1f, f0, 1'b1});
            u_tcc_host.wr(8'h28, {f0 + 2'h2, f0 + 2'h1, 4'hf});
            u_tcc_host.wr(8'h2b, {6'h3f, f0 + 2'h3});
            rd_chk(8'h25, {5'h00, f0, 1'b0});
            rd_chk(8'h28, {f0 + 2'h2, f0 + 2'h1, 4'h0});
            rd_chk(8'h2b, {6'h00, f0 + 2'h3});
            pulse_conv();
            check("tracks", {8'h00, cfg_out.fast_track},
                  {8'h00, f0 + 2'h3, f0 + 2'h2, f0 + 2'h1, f0});
        end
    endtask

    task automatic test_setup();
        logic [7:0] w;
        logic [7:0] exp;
        logic [7:0] prev;
        prev = 8'h04;
        for (int i = 0; i < 4; i++) begin
            w = {i[0], i[1:0], 5'h1f - i[4:0]};
            exp = {w[7], (i == 3) ? 2'h2 : i[1:0], w[4:0]};
            u_tcc_host.wr(8'h26, w);
            check("setup held", {8'h00, cfg_out[7:0]}, {8'h00, prev});
            rd_chk(8'h26, exp);
            pulse_conv();
            check("setup", {8'h00, cfg_out[7:0]}, {8'h00, exp});
            prev = exp;
        end
    endtask

    task automatic test_ro();
        for (int i = 0; i < 4; i++) begin
            u_tcc_host.wr(id_adr[i], ~id_val[i]);
            rd_chk(id_adr[i], id_val[i]);
        end
        u_tcc_host.wr(8'h30, 8'ha5);
        rd_chk(8'h30, 8'h00);
    endtask

    task automatic test_two_chan();
        u_tcc_host.wr(8'h25, 8'h04);
        u_tcc_host.wr(8'h28, 8'hf0);
        u_tcc_host.wr(8'h2b, 8'h02);
        u_tcc_host.wr(8'h26, 8'ha5);
        rd_two(8'h28, 8'hf0, 8'h70);
        rd_two(8'h2b, 8'h02, 8'h01);
        rd_two(8'h26, 8'ha5, 8'h04);
        rd_two(8'hfe, `TCC_PART_LO_4CH, `TCC_PART_LO_2CH);
        pulse_conv();
        check("2ch cfg", cfg_2ch, 16'h5e04);
    endtask

    task automatic test_scale();
        for (int s = 0; s < 4; s++) begin
            @(posedge sys_clk);
            #1;
            counter_scale = {2'(s + 3), 2'(s + 2), 2'(s + 1), 2'(s)};
            raw_counts = {16'hf00f, 16'h8421, 16'hffff, 16'h1234};
            @(posedge sys_clk);
            #1;
            for (int c = 0; c < 4; c++) begin
                check("scaled", scaled_counts[c],
                      raw_counts[c] >> counter_scale[c]);
                check("scaled 2ch", scaled_2ch[c],
                      raw_counts[c] >> counter_scale[c]);
            end
        end
    endtask

    // ----------------------------------------------------------------
    // Clock, timeout and main sequence
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
    end

    always #10 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            wrap_up();
        end
    end

    initial begin
        reset_n = 1'b0;
        conv_start = 1'b0;
        counter_scale = '0;
        raw_counts = '0;
        repeat (2) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        test_reset();
        test_track();
        test_setup();
        test_ro();
        test_two_chan();
        test_scale();
        wrap_up();
    end
endmodule
